//--- pkg/cpu_ops_defines.svh
`ifndef CPU_OPS_DEFINES_SVH
`define CPU_OPS_DEFINES_SVH
// Operation
// RULE1: Bit set forces indexed bit, writes back
// RULE2: Single-operand complement inverts destination in place
// RULE3: Two-operand complement writes inverted source elsewhere
// RULE4: Duplicate copies source value to destination
// RULE5: Per-operand select bit picks direct or indirect
// RULE6: Immediate port write drives constant byte out
// RULE7: Memory byte copied out to chosen port
// RULE8: Port byte AND constant, to port or memory
// RULE9: Port byte OR constant, to port or memory
// RULE10: Port byte stored to memory destination
// RULE11: Port bit copied to flag, zero flag default
// RULE12: Source is first value, other operand second
// RULE13: Compare with constant sets O S C Z only
// RULE14: Memory-to-memory compare sets O S C Z
// RULE15: Jump loads PC from constant or memory
// RULE16: Relational branch taken only when relation holds
// RULE17: Signedness bit one selects signed relation
// RULE18: Branch when selected flag is clear
// RULE19: Branch when selected flag is set
// RULE20: Call pushes PC plus two, SP minus three
// RULE21: Indirect call target read from source operand
// RULE22: False conditional call leaves stack and memory
// RULE23: Memory bit test also defaults to zero flag
// RULE24: Indirect access reads pointer, then the data

`define FLAG_ZERO_BIT     4'h0
`define FLAG_CARRY_BIT    4'h1
`define FLAG_SIGN_BIT     4'h2
`define FLAG_OVERFLOW_BIT 4'h3

`define PC_RESET          16'h0000
`define SP_RESET          16'hFFFF
`define FLAGS_RESET       16'h0000
`define PC_STEP           16'h0002
`define SP_STEP           16'h0003

`define MASK_BYTE         32'h000000FF
`define MASK_WORD         32'h0000FFFF
`define MASK_DWORD        32'hFFFFFFFF
`define ALIGN_BYTE        5'h18
`define ALIGN_WORD        5'h10
`define ALIGN_DWORD       5'h00
`endif

//--- pkg/cpu_ops_pkg.sv
package cpu_ops_pkg;

  // TRIPLE is used only for the pushed return address
  typedef enum logic [1:0] {
    SZ_BYTE   = 2'b00,
    SZ_WORD   = 2'b01,
    SZ_DWORD  = 2'b10,
    SZ_TRIPLE = 2'b11
  } size_t;

  typedef enum logic [4:0] {
    OP_BIT_SET_MEM           = 5'h00,
    OP_BIT_TEST_MEM          = 5'h01,
    OP_COMPLEMENT_IN_PLACE   = 5'h02,
    OP_COMPLEMENT_VALUE      = 5'h03,
    OP_DUPLICATE_VALUE       = 5'h04,
    OP_WRITE_PORT_IMM        = 5'h05,
    OP_WRITE_PORT_MEM        = 5'h06,
    OP_PORT_AND_MASK_PORT    = 5'h07,
    OP_PORT_AND_MASK_MEM     = 5'h08,
    OP_PORT_OR_MERGE_PORT    = 5'h09,
    OP_PORT_OR_MERGE_MEM     = 5'h0A,
    OP_READ_PORT_TO_MEM      = 5'h0B,
    OP_PORT_BIT_TEST         = 5'h0C,
    OP_COMPARE_IMM           = 5'h0D,
    OP_COMPARE_VALUES        = 5'h0E,
    OP_JUMP_IMM              = 5'h0F,
    OP_JUMP_MEM              = 5'h10,
    OP_BRANCH_RELATION       = 5'h11,
    OP_BRANCH_ON_CONDITION_CLEAR = 5'h12,
    OP_BRANCH_ON_CONDITION_SET   = 5'h13,
    OP_CALL_IMM              = 5'h14,
    OP_CALL_MEM              = 5'h15,
    OP_CALL_RELATION         = 5'h16
  } op_t;

  typedef enum logic [1:0] {
    REL_GREATER       = 2'b00,
    REL_GREATER_EQUAL = 2'b01,
    REL_LESS          = 2'b10,
    REL_LESS_EQUAL    = 2'b11
  } relation_t;

  typedef enum logic [3:0] {
    PH_IDLE    = 4'b0000,
    PH_SRC_PTR = 4'b0001,
    PH_SRC_RD  = 4'b0010,
    PH_IO_RD   = 4'b0011,
    PH_DST_PTR = 4'b0100,
    PH_DST_RD  = 4'b0101,
    PH_EXEC    = 4'b0110,
    PH_MEM_WR  = 4'b0111,
    PH_IO_WR   = 4'b1000,
    PH_PUSH    = 4'b1001,
    PH_FINISH  = 4'b1010
  } phase_t;

  typedef struct packed {
    op_t         op;
    size_t       size;
    relation_t   relation;
    logic        signed_compare_select;
    logic [15:0] src_addr;
    logic        src_pointer_mode;
    logic [15:0] dst_addr;
    logic        target_pointer_mode;
    logic [31:0] imm;
    logic [8:0]  port;
    logic [4:0]  bit_index;
    logic [3:0]  condition_selector;
    logic        flag_given;
    logic [15:0] rom_addr;
  } instr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    size_t       size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [8:0]  port;
    logic [7:0]  wdata;
  } io_req_t;

  typedef struct packed {
    logic src_ptr;
    logic src_rd;
    logic io_rd;
    logic dst_ptr;
    logic dst_rd;
    logic mem_wr;
    logic io_wr;
    logic push;
  } needs_t;

  typedef struct packed {
    phase_t      phase;
    instr_t      ins;
    needs_t      needs;
    logic        take;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [31:0] a;
    logic [31:0] b;
    logic [7:0]  port_val;
    logic [31:0] result;
    logic [15:0] target;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] flags;
    mem_req_t    mem;
    io_req_t     io;
    logic        done;
  } exec_state_t;

endpackage

//--- sim/mem_io_model.sv
module mem_io_model (
  input  wire logic                  mclk,      // Core clock
  input  wire cpu_ops_pkg::mem_req_t mem_o,     // Data memory request
  output logic                       mem_ack,   // Memory access done
  output logic [31:0]                mem_rdata, // Memory read data
  input  wire cpu_ops_pkg::io_req_t  io_o,      // Port request
  output logic                       io_ack,    // Port access done
  output logic [7:0]                 io_rdata   // Port read data
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_ops_pkg::*;
  logic [7:0]  mem  [0:65535];
  logic [7:0]  port [0:511];
  logic [1:0]  wait_n = 2'h0;
  logic        slow   = 1'b0;
  logic [15:0] a;
  assign a = mem_o.addr;
  // Alternate zero- and two-wait answers
  assign mem_ack = mem_o.req && (wait_n == {slow, 1'b0});
  assign io_ack  = io_o.req && (wait_n == {slow, 1'b0});
  // Off-answer data shows the inverse, never a stale match
  assign mem_rdata = {mem[a + 16'h3], mem[a + 16'h2], mem[a + 16'h1], mem[a]} ^ {32{!mem_ack}};
  assign io_rdata  = port[io_o.port] ^ {8{!io_ack}};
  always @(posedge mclk) begin
    if (mem_ack || io_ack) begin
      wait_n <= 2'h0;
      slow   <= !slow;
    end else if (mem_o.req || io_o.req) begin
      wait_n <= wait_n + 2'h1;
    end
    if (mem_ack && mem_o.we) begin
      mem[a] <= mem_o.wdata[7:0];
      if (mem_o.size != SZ_BYTE) mem[a + 16'h1] <= mem_o.wdata[15:8];
      if (mem_o.size[1]) mem[a + 16'h2] <= mem_o.wdata[23:16];
      if (mem_o.size == SZ_DWORD) mem[a + 16'h3] <= mem_o.wdata[31:24];
    end
    if (io_ack && io_o.we) port[io_o.port] <= io_o.wdata;
  end
endmodule // mem_io_model

//--- sim/test_cpu_ops_exec.sv
module test_cpu_ops_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_ops_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        issue = 1'b0;
  instr_t      instr = '0;
  logic        ready, done, mem_ack, io_ack;
  mem_req_t    mem_o;
  io_req_t     io_o;
  logic [31:0] mem_rdata;
  logic [7:0]  io_rdata;
  logic [15:0] pc, stack_top_pointer, flags, cur_pc;
  int          err_total = 0;
  int          checks_done = 0;
  instr_t      ins;
  cpu_ops_exec cpu_ops_exec_i (.mclk(mclk), .reset_n(reset_n), .issue(issue), .instr(instr), .ready(ready),
    .done(done), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .io_o(io_o), .io_ack(io_ack),
    .io_rdata(io_rdata), .pc(pc), .stack_top_pointer(stack_top_pointer), .flags(flags));
  mem_io_model mem_io_model_i (.mclk(mclk), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .io_o(io_o), .io_ack(io_ack), .io_rdata(io_rdata));
  initial begin
    forever #4 mclk = !mclk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic instr_t mk(op_t op, size_t sz, logic [15:0] s, logic [15:0] d);
    mk = '0;
    mk.op = op;
    mk.size = sz;
    mk.src_addr = s;
    mk.dst_addr = d;
  endfunction
  task automatic poke(logic [15:0] a, logic [31:0] v);
    for (int k = 0; k < 4; k++) mem_io_model_i.mem[a + 16'(k)] = v[8*k +: 8];
  endtask
  function automatic logic [31:0] peek(logic [15:0] a);
    return {mem_io_model_i.mem[a + 16'h3], mem_io_model_i.mem[a + 16'h2], mem_io_model_i.mem[a + 16'h1],
            mem_io_model_i.mem[a]};
  endfunction
  task automatic step(instr_t i);
    run(i, cur_pc + 16'h2);
  endtask
  task automatic run(instr_t i, logic [15:0] new_pc);
    int n;
    @(negedge mclk);
    instr = i;
    issue = 1'b1;
    @(negedge mclk);
    issue = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("done", 1, done);
    chk("pc", new_pc, pc);
    cur_pc = new_pc;
  endtask
  task automatic t_reset;
    chk("ready", 1, ready);
    chk("pc", 32'h0, pc);
    chk("sp", 32'hFFFF, stack_top_pointer);
    chk("flags", 32'h0, flags);
    cur_pc = 16'h0000;
  endtask
  task automatic t_mem_ops;
    poke(16'h0100, 32'h00000200);
    poke(16'h0200, 32'h11111111);
    ins = mk(OP_BIT_SET_MEM, SZ_WORD, 16'h0, 16'h0100);
    ins.target_pointer_mode = 1'b1;
    ins.bit_index = 5'h0F;
    step(ins);
    chk("bit set", 32'h11119111, peek(16'h0200));
    poke(16'h0300, 32'h12345678);
    step(mk(OP_COMPLEMENT_IN_PLACE, SZ_BYTE, 16'h0, 16'h0300));
    chk("inv inplace", 32'h12345687, peek(16'h0300));
    step(mk(OP_COMPLEMENT_VALUE, SZ_DWORD, 16'h0300, 16'h0310));
    chk("inv dst", 32'hEDCBA978, peek(16'h0310));
    chk("inv src", 32'h12345687, peek(16'h0300));
    poke(16'h0320, 32'h00000330);
    poke(16'h0330, 32'hAAAABEEF);
    poke(16'h0340, 32'h0);
    ins = mk(OP_DUPLICATE_VALUE, SZ_WORD, 16'h0320, 16'h0340);
    ins.src_pointer_mode = 1'b1;
    step(ins);
    chk("copy", 32'h0000BEEF, peek(16'h0340));
  endtask
  task automatic t_ports;
    ins = mk(OP_WRITE_PORT_IMM, SZ_BYTE, 16'h0, 16'h0);
    ins.port = 9'h1A5;
    ins.imm = 32'h5C;
    step(ins);
    chk("port imm", 32'h5C, mem_io_model_i.port[9'h1A5]);
    ins = mk(OP_WRITE_PORT_MEM, SZ_BYTE, 16'h0300, 16'h0);
    ins.port = 9'h101;
    step(ins);
    chk("port mem", 32'h87, mem_io_model_i.port[9'h101]);
    ins = mk(OP_PORT_AND_MASK_PORT, SZ_BYTE, 16'h0, 16'h0);
    ins.port = 9'h1A5;
    ins.imm = 32'h0F;
    step(ins);
    chk("and port", 32'h0C, mem_io_model_i.port[9'h1A5]);
    poke(16'h0350, 32'h0);
    ins = mk(OP_PORT_OR_MERGE_MEM, SZ_BYTE, 16'h0, 16'h0350);
    ins.port = 9'h101;
    ins.imm = 32'h30;
    step(ins);
    chk("or mem", 32'hB7, peek(16'h0350));
    ins = mk(OP_READ_PORT_TO_MEM, SZ_BYTE, 16'h0, 16'h0352);
    ins.port = 9'h1A5;
    step(ins);
    chk("in mem", 32'h0C, peek(16'h0352) & 32'h000000FF);
  endtask
  task automatic t_tests;
    ins = mk(OP_PORT_BIT_TEST, SZ_BYTE, 16'h0, 16'h0);
    ins.port = 9'h1A5;
    ins.bit_index = 5'h02;
    step(ins);
    chk("test zero", 32'h1, flags[0]);
    ins.flag_given = 1'b1;
    ins.condition_selector = 4'h1;
    step(ins);
    chk("test carry", 32'h3, flags[1:0]);
    poke(16'h0390, 32'h01);
    ins = mk(OP_BIT_TEST_MEM, SZ_BYTE, 16'h0390, 16'h0);
    ins.bit_index = 5'h01;
    step(ins);
    chk("mem test", 32'h2, flags[1:0]);
  endtask
  task automatic t_compare;
    poke(16'h0360, 32'h80);
    ins = mk(OP_COMPARE_IMM, SZ_BYTE, 16'h0360, 16'h0);
    ins.imm = 32'h01;
    step(ins);
    chk("cmp flags", 32'h8, flags[3:0]);
    chk("cmp mem", 32'h80, peek(16'h0360));
    ins = mk(OP_BRANCH_RELATION, SZ_BYTE, 16'h0, 16'h0);
    ins.rom_addr = 16'h0400;
    run(ins, 16'h0400);
    ins.signed_compare_select = 1'b1;
    step(ins);
    ins.relation = REL_LESS;
    run(ins, 16'h0400);
    poke(16'h0370, 32'h00050005);
    step(mk(OP_COMPARE_VALUES, SZ_WORD, 16'h0370, 16'h0372));
    chk("cmp eq", 32'h1, flags[3:0]);
    ins.relation = REL_LESS;
    ins.signed_compare_select = 1'b0;
    step(ins);
    ins.relation = REL_GREATER_EQUAL;
    run(ins, 16'h0400);
  endtask
  task automatic t_flow;
    ins = mk(OP_BRANCH_ON_CONDITION_CLEAR, SZ_BYTE, 16'h0, 16'h0);
    ins.rom_addr = 16'h0600;
    step(ins);
    ins.condition_selector = 4'h1;
    run(ins, 16'h0600);
    ins.op = OP_BRANCH_ON_CONDITION_SET;
    step(ins);
    ins.condition_selector = 4'h0;
    run(ins, 16'h0600);
    ins.op = OP_JUMP_IMM;
    run(ins, 16'h0600);
    poke(16'h0380, 32'h00000A00);
    run(mk(OP_JUMP_MEM, SZ_WORD, 16'h0380, 16'h0), 16'h0A00);
  endtask
  task automatic t_call;
    ins = mk(OP_CALL_IMM, SZ_BYTE, 16'h0, 16'h0);
    ins.rom_addr = 16'h0C00;
    run(ins, 16'h0C00);
    chk("push", 32'h000A02, peek(16'hFFFF) & 32'h00FFFFFF);
    chk("sp", 32'hFFFC, stack_top_pointer);
    poke(16'hFFF9, 32'h0);
    run(mk(OP_CALL_MEM, SZ_WORD, 16'h0380, 16'h0), 16'h0A00);
    chk("push2", 32'h000C02, peek(16'hFFFC) & 32'h00FFFFFF);
    chk("sp2", 32'hFFF9, stack_top_pointer);
    ins.op = OP_CALL_RELATION;
    ins.relation = REL_LESS;
    step(ins);
    chk("sp3", 32'hFFF9, stack_top_pointer);
    chk("stack", 32'h0, peek(16'hFFF9) & 32'h00FFFFFF);
    ins.relation = REL_LESS_EQUAL;
    run(ins, 16'h0C00);
    chk("sp4", 32'hFFF6, stack_top_pointer);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    t_reset();
    t_mem_ops();
    t_ports();
    t_tests();
    t_compare();
    t_flow();
    t_call();
    wrap_up();
  end
endmodule // test_cpu_ops_exec

//--- verilog/cpu_ops_compare.sv
`include "cpu_ops_defines.svh"

module cpu_ops_compare (
  input  wire logic [31:0]       a,        // First value, the source operand
  input  wire logic [31:0]       b,        // Second value, constant or destination
  input  wire cpu_ops_pkg::size_t size,    // Operand width
  output logic                   overflow, // Signed overflow of a minus b
  output logic                   sign,     // Sign of a minus b
  output logic                   carry,    // Borrow, a below b unsigned
  output logic                   zero      // a equals b
);
  import cpu_ops_pkg::*;

  logic [4:0]  align;
  logic [31:0] a_top;
  logic [31:0] b_top;
  logic [32:0] diff;

  // Operands are moved to the top so one 32-bit subtractor serves every width
  always_comb begin
    unique case (size)
      SZ_BYTE:  align = `ALIGN_BYTE;
      SZ_WORD:  align = `ALIGN_WORD;
      default:  align = `ALIGN_DWORD;
    endcase
    a_top    = a << align;
    b_top    = b << align;
    diff     = {1'b0, a_top} - {1'b0, b_top};
    carry    = diff[32];
    zero     = (diff[31:0] == 32'h00000000);
    sign     = diff[31];
    overflow = (a_top[31] ^ b_top[31]) & (a_top[31] ^ diff[31]);
  end

endmodule // cpu_ops_compare

//--- verilog/cpu_ops_exec.sv
`include "cpu_ops_defines.svh"

module cpu_ops_exec (
  input  wire logic                  mclk,              // Core clock, 125 MHz
  input  wire logic                  reset_n,           // Synchronous reset, active low
  input  wire logic                  issue,             // Instruction offered
  input  wire cpu_ops_pkg::instr_t   instr,             // Decoded instruction fields
  output logic                       ready,             // Idle; instruction taken with issue
  output logic                       done,              // One-cycle retire pulse
  output cpu_ops_pkg::mem_req_t      mem_o,             // Data memory request, held until ack
  input  wire logic                  mem_ack,           // Memory access complete
  input  wire logic [31:0]           mem_rdata,         // Read data, low bits
  output cpu_ops_pkg::io_req_t       io_o,              // I/O port request, held until ack
  input  wire logic                  io_ack,            // Port access complete
  input  wire logic [7:0]            io_rdata,          // Port read data
  output logic [15:0]                pc,                // Program counter
  output logic [15:0]                stack_top_pointer, // Stack pointer
  output logic [15:0]                flags              // Flag register
);
  import cpu_ops_pkg::*;

  exec_state_t s;
  exec_state_t n;
  logic        cmp_overflow;
  logic        cmp_sign;
  logic        cmp_carry;
  logic        cmp_zero;
  logic [31:0] cmp_b;

  function automatic logic [31:0] size_mask(size_t sz);
    unique case (sz)
      SZ_BYTE:  size_mask = `MASK_BYTE;
      SZ_WORD:  size_mask = `MASK_WORD;
      default:  size_mask = `MASK_DWORD;
    endcase
  endfunction

  // Port traffic is always a byte; code addresses are a word
  function automatic size_t op_size(instr_t i);
    unique case (i.op)
      OP_WRITE_PORT_MEM, OP_PORT_AND_MASK_MEM, OP_PORT_OR_MERGE_MEM,
      OP_READ_PORT_TO_MEM:   op_size = SZ_BYTE;
      OP_JUMP_MEM, OP_CALL_MEM: op_size = SZ_WORD;
      default:               op_size = i.size;
    endcase
  endfunction

  function automatic logic cond_take(instr_t i, logic [15:0] f);
    logic c;
    logic z;
    logic lt_s;
    c    = f[`FLAG_CARRY_BIT];
    z    = f[`FLAG_ZERO_BIT];
    lt_s = f[`FLAG_SIGN_BIT] ^ f[`FLAG_OVERFLOW_BIT];
    cond_take = 1'b1;
    if (i.op == OP_BRANCH_RELATION || i.op == OP_CALL_RELATION) begin
      unique case (i.relation)
        REL_GREATER:       cond_take = i.signed_compare_select ? (!lt_s && !z) : (!c && !z); // RULE16 RULE17
        REL_GREATER_EQUAL: cond_take = i.signed_compare_select ? !lt_s : !c; // RULE16 RULE17
        REL_LESS:          cond_take = i.signed_compare_select ? lt_s : c; // RULE16 RULE17
        REL_LESS_EQUAL:    cond_take = i.signed_compare_select ? (lt_s || z) : (c || z); // RULE16 RULE17
      endcase
    end else if (i.op == OP_BRANCH_ON_CONDITION_CLEAR) begin
      cond_take = !f[i.condition_selector]; // RULE18
    end else if (i.op == OP_BRANCH_ON_CONDITION_SET) begin
      cond_take = f[i.condition_selector];  // RULE19
    end
  endfunction

  function automatic needs_t decode(instr_t i, logic take);
    needs_t d;
    logic   dst_addr_used;
    d = '0;
    unique case (i.op)
      OP_BIT_TEST_MEM, OP_COMPLEMENT_VALUE, OP_DUPLICATE_VALUE, OP_WRITE_PORT_MEM,
      OP_COMPARE_IMM, OP_COMPARE_VALUES, OP_JUMP_MEM, OP_CALL_MEM: d.src_rd = 1'b1;
      default: d.src_rd = 1'b0;
    endcase
    unique case (i.op)
      OP_PORT_AND_MASK_PORT, OP_PORT_AND_MASK_MEM, OP_PORT_OR_MERGE_PORT,
      OP_PORT_OR_MERGE_MEM, OP_READ_PORT_TO_MEM, OP_PORT_BIT_TEST: d.io_rd = 1'b1;
      default: d.io_rd = 1'b0;
    endcase
    d.dst_rd = (i.op == OP_BIT_SET_MEM) || (i.op == OP_COMPLEMENT_IN_PLACE) || (i.op == OP_COMPARE_VALUES);
    unique case (i.op)
      OP_BIT_SET_MEM, OP_COMPLEMENT_IN_PLACE, OP_COMPLEMENT_VALUE, OP_DUPLICATE_VALUE,
      OP_PORT_AND_MASK_MEM, OP_PORT_OR_MERGE_MEM, OP_READ_PORT_TO_MEM: d.mem_wr = 1'b1;
      default: d.mem_wr = 1'b0;
    endcase
    d.io_wr = (i.op == OP_WRITE_PORT_IMM) || (i.op == OP_WRITE_PORT_MEM) ||
              (i.op == OP_PORT_AND_MASK_PORT) || (i.op == OP_PORT_OR_MERGE_PORT);
    // A call whose condition fails never reaches the push phase
    d.push = (i.op == OP_CALL_IMM) || (i.op == OP_CALL_MEM) || (i.op == OP_CALL_RELATION && take); // RULE22
    dst_addr_used = d.dst_rd || d.mem_wr;
    d.src_ptr = d.src_rd && i.src_pointer_mode;         // RULE5
    d.dst_ptr = dst_addr_used && i.target_pointer_mode; // RULE5
    decode = d;
  endfunction

  // Next needed phase after 'from'
  function automatic phase_t pick(phase_t from, needs_t d);
    pick = PH_FINISH;
    if (d.push && from < PH_PUSH) pick = PH_PUSH;
    if (d.io_wr && from < PH_IO_WR) pick = PH_IO_WR;
    if (d.mem_wr && from < PH_MEM_WR) pick = PH_MEM_WR;
    if (from < PH_EXEC) pick = PH_EXEC;
    if (d.dst_rd && from < PH_DST_RD) pick = PH_DST_RD;
    if (d.dst_ptr && from < PH_DST_PTR) pick = PH_DST_PTR;
    if (d.io_rd && from < PH_IO_RD) pick = PH_IO_RD;
    if (d.src_rd && from < PH_SRC_RD) pick = PH_SRC_RD;
    if (d.src_ptr && from < PH_SRC_PTR) pick = PH_SRC_PTR;
  endfunction

  // Enter a phase and raise its request
  function automatic exec_state_t launch(exec_state_t x, phase_t p);
    x.phase     = p;
    x.mem.req   = 1'b0;
    x.mem.we    = 1'b0;
    x.io.req    = 1'b0;
    x.io.we     = 1'b0;
    x.mem.size  = op_size(x.ins);
    x.mem.wdata = x.result;
    x.io.port   = x.ins.port;
    x.io.wdata  = x.result[7:0];
    case (p)
      PH_SRC_PTR: begin
        x.mem.req  = 1'b1;  // RULE24
        x.mem.addr = x.ins.src_addr;
        x.mem.size = SZ_WORD;
      end
      PH_SRC_RD: begin
        x.mem.req  = 1'b1;
        x.mem.addr = x.src_ea;
      end
      PH_IO_RD: begin
        x.io.req = 1'b1;
      end
      PH_DST_PTR: begin
        x.mem.req  = 1'b1;  // RULE24
        x.mem.addr = x.ins.dst_addr;
        x.mem.size = SZ_WORD;
      end
      PH_DST_RD: begin
        x.mem.req  = 1'b1;
        x.mem.addr = x.dst_ea;
      end
      PH_MEM_WR: begin
        x.mem.req  = 1'b1;
        x.mem.we   = 1'b1;
        x.mem.addr = x.dst_ea;
      end
      PH_IO_WR: begin
        x.io.req = 1'b1;
        x.io.we  = 1'b1;
      end
      PH_PUSH: begin
        x.mem.req   = 1'b1; // RULE20
        x.mem.we    = 1'b1;
        x.mem.addr  = x.sp;
        x.mem.size  = SZ_TRIPLE;
        x.mem.wdata = {16'h0000, x.pc + `PC_STEP};
      end
      default: x.mem.addr = x.mem.addr;
    endcase
    launch = x;
  endfunction

  assign cmp_b = (s.ins.op == OP_COMPARE_IMM) ? s.ins.imm : s.b; // RULE12

  cpu_ops_compare u_compare (
    .a        (s.a),
    .b        (cmp_b),
    .size     (s.ins.size),
    .overflow (cmp_overflow),
    .sign     (cmp_sign),
    .carry    (cmp_carry),
    .zero     (cmp_zero)
  );

  always_comb begin
    logic [3:0]  flag_sel;
    logic [31:0] mask;
    logic [31:0] rd;
    n        = s;
    n.done   = 1'b0;
    flag_sel = s.ins.flag_given ? s.ins.condition_selector : `FLAG_ZERO_BIT; // RULE11 RULE23
    mask     = size_mask(op_size(s.ins));
    rd       = mem_rdata & mask;
    unique case (s.phase)
      PH_IDLE: begin
        if (issue) begin
          n.ins    = instr;
          n.take   = cond_take(instr, s.flags);
          n.needs  = decode(instr, n.take);
          n.src_ea = instr.src_addr;
          n.dst_ea = instr.dst_addr;
          n.result = instr.imm;
          n        = launch(n, pick(PH_IDLE, n.needs));
        end
      end
      PH_SRC_PTR: begin
        if (mem_ack) begin
          n.src_ea = mem_rdata[15:0]; // RULE24
          n        = launch(n, pick(PH_SRC_PTR, s.needs));
        end
      end
      PH_SRC_RD: begin
        if (mem_ack) begin
          n.a = rd;
          n   = launch(n, pick(PH_SRC_RD, s.needs));
        end
      end
      PH_IO_RD: begin
        if (io_ack) begin
          n.port_val = io_rdata;
          n          = launch(n, pick(PH_IO_RD, s.needs));
        end
      end
      PH_DST_PTR: begin
        if (mem_ack) begin
          n.dst_ea = mem_rdata[15:0]; // RULE24
          n        = launch(n, pick(PH_DST_PTR, s.needs));
        end
      end
      PH_DST_RD: begin
        if (mem_ack) begin
          n.b = rd;
          n   = launch(n, pick(PH_DST_RD, s.needs));
        end
      end
      PH_EXEC: begin
        n.target = s.pc + `PC_STEP;
        unique case (s.ins.op)
          OP_BIT_SET_MEM:         n.result = (s.b | (32'h00000001 << s.ins.bit_index)) & mask; // RULE1
          OP_BIT_TEST_MEM:        n.flags[flag_sel] = s.a[s.ins.bit_index]; // RULE23
          OP_COMPLEMENT_IN_PLACE: n.result = ~s.b & mask; // RULE2
          OP_COMPLEMENT_VALUE:    n.result = ~s.a & mask; // RULE3
          OP_DUPLICATE_VALUE:     n.result = s.a; // RULE4
          OP_WRITE_PORT_IMM:      n.result = {24'h000000, s.ins.imm[7:0]}; // RULE6
          OP_WRITE_PORT_MEM:      n.result = {24'h000000, s.a[7:0]}; // RULE7
          OP_PORT_AND_MASK_PORT, OP_PORT_AND_MASK_MEM:
            n.result = {24'h000000, s.port_val & s.ins.imm[7:0]}; // RULE8
          OP_PORT_OR_MERGE_PORT, OP_PORT_OR_MERGE_MEM:
            n.result = {24'h000000, s.port_val | s.ins.imm[7:0]}; // RULE9
          OP_READ_PORT_TO_MEM:    n.result = {24'h000000, s.port_val}; // RULE10
          // Index values 8 to 15 point past the byte and read as zero
          OP_PORT_BIT_TEST:
            n.flags[flag_sel] = !s.ins.bit_index[3] && s.port_val[s.ins.bit_index[2:0]]; // RULE11
          OP_COMPARE_IMM, OP_COMPARE_VALUES: begin
            n.flags[`FLAG_OVERFLOW_BIT] = cmp_overflow; // RULE13 RULE14
            n.flags[`FLAG_SIGN_BIT]     = cmp_sign;     // RULE13 RULE14
            n.flags[`FLAG_CARRY_BIT]    = cmp_carry;    // RULE13 RULE14
            n.flags[`FLAG_ZERO_BIT]     = cmp_zero;     // RULE13 RULE14
          end
          OP_JUMP_IMM, OP_CALL_IMM:  n.target = s.ins.rom_addr; // RULE15 RULE20
          OP_JUMP_MEM, OP_CALL_MEM:  n.target = s.a[15:0];      // RULE15 RULE21
          OP_BRANCH_RELATION, OP_CALL_RELATION, OP_BRANCH_ON_CONDITION_CLEAR, OP_BRANCH_ON_CONDITION_SET:
            n.target = s.take ? s.ins.rom_addr : s.pc + `PC_STEP; // RULE16 RULE18 RULE19 RULE22
          default: n.result = s.result;
        endcase
        n = launch(n, pick(PH_EXEC, s.needs));
      end
      PH_MEM_WR, PH_IO_WR: begin
        if ((s.phase == PH_MEM_WR && mem_ack) || (s.phase == PH_IO_WR && io_ack)) begin
          n = launch(n, PH_FINISH);
        end
      end
      PH_PUSH: begin
        if (mem_ack) begin
          n.sp = s.sp - `SP_STEP; // RULE20
          n    = launch(n, PH_FINISH);
        end
      end
      PH_FINISH: begin
        n.pc    = s.target; // RULE15
        n.done  = 1'b1;
        n.phase = PH_IDLE;
      end
      default: n = launch(n, PH_IDLE);
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s       <= '0;
      s.pc    <= `PC_RESET;
      s.sp    <= `SP_RESET;
      s.flags <= `FLAGS_RESET;
    end else begin
      s <= n;
    end
  end

  assign ready             = (s.phase == PH_IDLE);
  assign done              = s.done;
  assign mem_o             = s.mem;
  assign io_o              = s.io;
  assign pc                = s.pc;
  assign stack_top_pointer = s.sp;
  assign flags             = s.flags;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence src_indirect_taken;
    ready && issue && decode(instr, 1'b1).src_ptr;
  endsequence

  sequence push_acked;
    s.phase == PH_PUSH && mem_ack;
  endsequence

  pointer_first_a: assert property (src_indirect_taken |=> s.phase == PH_SRC_PTR && mem_o.req && !mem_o.we && mem_o.addr == $past(instr.src_addr)) else $error("pointer not read first"); // RULE24
  push_value_a: assert property (s.phase == PH_PUSH |-> mem_o.we && mem_o.addr == s.sp && mem_o.wdata[15:0] == s.pc + 16'h0002) else $error("return address push is wrong"); // RULE20
  push_stack_a: assert property (push_acked |=> s.sp == $past(s.sp) - 16'h0003 ##1 s.done && s.pc == $past(s.target, 2)) else $error("call stack or pc wrong"); // RULE20
  jump_lands_a: assert property (ready && issue && instr.op == OP_JUMP_IMM |=> ##2 done && pc == $past(instr.rom_addr, 3)) else $error("jump target wrong"); // RULE15
  compare_silent_a: assert property (!ready && (s.ins.op == OP_COMPARE_IMM || s.ins.op == OP_COMPARE_VALUES) |-> !mem_o.we && !io_o.req) else $error("compare wrote something"); // RULE13
  call_false_a: assert property (!ready && s.ins.op == OP_CALL_RELATION && !s.take |-> !mem_o.we ##1 s.sp == $past(s.sp)) else $error("false call touched the stack"); // RULE22
  branch_skip_a: assert property (s.phase == PH_FINISH && s.ins.op == OP_BRANCH_RELATION && !s.take |=> pc == $past(s.pc) + 16'h0002) else $error("untaken branch did not fall through"); // RULE16
  port_imm_a: assert property (io_o.we && s.ins.op == OP_WRITE_PORT_IMM |-> io_o.req && io_o.wdata == s.ins.imm[7:0] && io_o.port == s.ins.port) else $error("port write data wrong"); // RULE6
  complement_a: assert property (mem_o.we && s.ins.op == OP_COMPLEMENT_IN_PLACE |-> (mem_o.wdata ^ s.b) == size_mask(s.ins.size) && mem_o.addr == s.dst_ea) else $error("in-place complement wrong"); // RULE2
  bit_set_a: assert property (mem_o.we && s.ins.op == OP_BIT_SET_MEM |-> ((mem_o.wdata ^ s.b) & ~(32'h00000001 << s.ins.bit_index)) == 32'h00000000) else $error("bit set changed other bits"); // RULE1
  port_test_a: assert property (s.phase == PH_EXEC && s.ins.op == OP_PORT_BIT_TEST && !s.ins.flag_given && !s.ins.bit_index[3] |=> flags[0] == $past(s.port_val[s.ins.bit_index[2:0]])) else $error("port bit test missed zero flag"); // RULE11

endmodule // cpu_ops_exec
